// >>> inc/mrh_pkg.sv
// shared constants and types for the modbus radio hub status and serial block
// assumes one 125 MHz system clock and a synchronous active-high reset
package mrh_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int HOST_BAUD = 115_200;
    localparam int RADIO_BAUD = 19_200;
    localparam int HOST_DIV = CLK_HZ / HOST_BAUD;
    localparam int RADIO_DIV = CLK_HZ / RADIO_BAUD;
    localparam int CHAR_BITS = 10;
    localparam int GAP_TENTHS = 35;
    localparam int HOST_GAP_CYC = GAP_TENTHS * CHAR_BITS / 10 * HOST_DIV;
    localparam int RADIO_GAP_CYC = GAP_TENTHS * CHAR_BITS / 10 * RADIO_DIV;
    localparam int TIMEOUT_S = 3;
    localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
    localparam int HB_MS = 500;
    localparam int HB_CYC = HB_MS * (CLK_HZ / 1000);
    localparam int BLINK_MS = 50;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int MAX_REGS = 92;
    localparam int MAX_BYTES = 2 * MAX_REGS;
    localparam int BUF_DEPTH = 256;
    localparam int NUM_RADIOS = 8;
    localparam int RADIO_GROUP_SHIFT = 4;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam int MIN_FRAME = 4;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_HRX = 6'h02,
        ST_RTX = 6'h04,
        ST_RWAIT = 6'h08,
        ST_HTX = 6'h10,
        ST_CTX = 6'h20
    } mrh_state_t;
endpackage

// >>> hw/mrh_uart.sv
// 8-N-1 serial transmitter and receiver with end-of-frame gap detection
// assumes rx_pin is asynchronous; tx_start comes from logic on mclk
`timescale 1ns/10ps
module mrh_uart #(
    parameter int DIV = 1085,
    parameter int GAP = 37975
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic rx_pin,
    input wire logic [7:0] tx_data,
    input wire logic tx_start,
    output logic tx_pin,
    output logic tx_busy,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic frame_end
);
    import mrh_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic rx_act;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_valid;
        logic [17:0] gap_cnt;
        logic armed;
        logic frame_end;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_pin;
    } mrh_uart_t;

    localparam mrh_uart_t URST = '{s1: 1'b1, s2: 1'b1, tx_pin: 1'b1, default: '0};

    mrh_uart_t q, d;

    // receive samples mid-bit, lsb first; gap end arms only after a good byte
    always_comb
    begin
        d = q;
        d.s1 = rx_pin;
        d.s2 = q.s1;
        d.rx_valid = 1'b0;
        d.frame_end = 1'b0;
        if (q.rx_act || !q.s2)
            d.gap_cnt = '0;
        else if (q.gap_cnt != 18'(GAP))
            d.gap_cnt = q.gap_cnt + 18'h00001;
        if (q.armed && q.gap_cnt == 18'(GAP - 1))
        begin
            d.frame_end = 1'b1;
            d.armed = 1'b0;
        end
        if (!q.rx_act)
        begin
            if (!q.s2)
            begin
                d.rx_act = 1'b1;
                d.rx_cnt = 16'(DIV / 2);
                d.rx_bit = 4'h0;
            end
        end
        else if (q.rx_cnt != 16'h0000)
            d.rx_cnt = q.rx_cnt - 16'h0001;
        else
        begin
            d.rx_cnt = 16'(DIV - 1);
            d.rx_bit = q.rx_bit + 4'h1;
            if (q.rx_bit == 4'h0)
                d.rx_act = !q.s2; // glitch, not a start bit
            else if (q.rx_bit < 4'h9)
                d.rx_sh = {q.s2, q.rx_sh[7:1]}; // RULE_13
            else
            begin
                d.rx_act = 1'b0;
                if (q.s2) // RULE_10
                begin
                    d.rx_valid = 1'b1;
                    d.rx_data = q.rx_sh;
                    d.armed = 1'b1;
                end
            end
        end
        // transmit start, eight data bits lsb first, one stop
        if (!q.tx_busy)
        begin
            if (tx_start)
            begin
                d.tx_busy = 1'b1;
                d.tx_sh = {1'b1, tx_data, 1'b0}; // RULE_10
                d.tx_cnt = 16'h0000;
                d.tx_bit = 4'h0;
            end
        end
        else if (q.tx_cnt != 16'h0000)
            d.tx_cnt = q.tx_cnt - 16'h0001;
        else if (q.tx_bit == 4'(CHAR_BITS))
            d.tx_busy = 1'b0;
        else
        begin
            d.tx_pin = q.tx_sh[0]; // RULE_13
            d.tx_sh = {1'b1, q.tx_sh[9:1]};
            d.tx_cnt = 16'(DIV - 1);
            d.tx_bit = q.tx_bit + 4'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            q <= URST;
        else
            q <= d;
    end

    assign tx_pin = q.tx_pin;
    assign tx_busy = q.tx_busy;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_valid;
    assign frame_end = q.frame_end;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_tx_start_low: assert property (tx_start && !tx_busy |-> ##2 !tx_pin) // RULE_13
        else $error("start bit not low");
    a_tx_idle_high: assert property (!tx_busy |-> tx_pin) // RULE_13
        else $error("idle line not high");
endmodule

// >>> hw/mrh_hub.sv
// hub serial core: host rtu port, radio link, prefetch cache, status lamps
// assumes pins and ethernet phy status are asynchronous, config is on mclk
// Contract
// RULE_01: heartbeat lamp pulses while running normally
// RULE_02: serial lamp on at request, off after response
// RULE_03: amber lamp steadily shows network link status
// RULE_04: green lamp blinks while network traffic present
// RULE_05: eight radio lamps, on request, off when processed
// RULE_06: abandon radio attempt after 3 s, resume
// RULE_07: read request limited to 92 registers, 184 bytes
// RULE_08: radio link runs at 19,200 bps
// RULE_09: host port at 115,200 bps, buffered, reformatted
// RULE_10: characters are 8-N-1 on the host port
// RULE_11: host waits response timeout between commands
// RULE_12: cached reads answered locally, no radio traffic
// RULE_13: lsb first, idle high, start low, stop high
`timescale 1ns/10ps
module mrh_hub
    import mrh_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = mrh_pkg::TIMEOUT_CYC,
    parameter int HB_CYCLES = mrh_pkg::HB_CYC,
    parameter int BLINK_CYCLES = mrh_pkg::BLINK_CYC,
    parameter int HOST_GAP = mrh_pkg::HOST_GAP_CYC,
    parameter int RADIO_GAP = mrh_pkg::RADIO_GAP_CYC
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic host_rx,
    output logic host_tx,
    input wire logic radio_rx,
    output logic radio_tx,
    input wire logic eth_link,
    input wire logic eth_activity,
    input wire logic pf_en,
    input wire logic [15:0] pf_base,
    input wire logic [6:0] pf_count,
    input wire logic cache_we,
    input wire logic [6:0] cache_addr,
    input wire logic [15:0] cache_wdata,
    output logic led_heartbeat,
    output logic led_serial,
    output logic led_eth_amber,
    output logic led_eth_green,
    output logic [7:0] led_radio
);
    import mrh_pkg::*;

    typedef struct packed {
        mrh_state_t st;
        logic [8:0] len;
        logic [8:0] idx;
        logic [28:0] tmo;
        logic [2:0] sel;
        logic [15:0] crc;
        logic htx_start;
        logic [7:0] htx_data;
        logic rtx_start;
        logic [7:0] rtx_data;
        logic serial_led;
        logic [7:0] radio_led;
        logic [26:0] hb_cnt;
        logic hb_led;
        logic [26:0] blk_cnt;
        logic act_seen;
        logic green;
        logic amber;
        logic [1:0] link_s;
        logic [1:0] act_s;
    } mrh_hub_t;

    mrh_hub_t q, d;
    logic [7:0] buf_mem [BUF_DEPTH];
    logic [15:0] cache_mem [MAX_REGS];
    logic buf_we;
    logic [7:0] buf_waddr;
    logic [7:0] buf_wdata;
    logic h_busy, h_valid, h_end, r_busy, r_valid, r_end;
    logic [7:0] h_data, r_data;

    // crc-16 of one byte, reflected polynomial as used on rtu frames
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    // host port is the fast side, radio is the fixed slow side
    mrh_uart #(.DIV(HOST_DIV), .GAP(HOST_GAP)) u_host ( // RULE_09
        .mclk(mclk), .srst(srst), .rx_pin(host_rx), .tx_data(q.htx_data),
        .tx_start(q.htx_start), .tx_pin(host_tx), .tx_busy(h_busy),
        .rx_data(h_data), .rx_valid(h_valid), .frame_end(h_end));
    mrh_uart #(.DIV(RADIO_DIV), .GAP(RADIO_GAP)) u_radio ( // RULE_08
        .mclk(mclk), .srst(srst), .rx_pin(radio_rx), .tx_data(q.rtx_data),
        .tx_start(q.rtx_start), .tx_pin(radio_tx), .tx_busy(r_busy),
        .rx_data(r_data), .rx_valid(r_valid), .frame_end(r_end));

    // request fields decoded straight from the held frame
    logic [15:0] req_start, req_qty;
    logic is_read, too_long, cache_hit;
    logic [7:0] q2;
    logic [8:0] didx;
    logic [7:0] cbyte;
    logic [15:0] cword;
    always_comb
    begin
        req_start = {buf_mem[2], buf_mem[3]};
        req_qty = {buf_mem[4], buf_mem[5]};
        is_read = buf_mem[1] == FC_READ_HOLD;
        too_long = is_read && req_qty > 16'(MAX_REGS); // RULE_07
        cache_hit = pf_en && is_read && req_start >= pf_base
            && ({1'b0, req_start} + {1'b0, req_qty}) <= ({1'b0, pf_base} + 17'(pf_count));
        q2 = 8'(req_qty << 1);
        didx = q.idx - 9'h003;
        cword = cache_mem[7'(7'(req_start - pf_base) + 7'(didx >> 1))];
        if (q.idx == 9'h000)
            cbyte = buf_mem[0];
        else if (q.idx == 9'h001)
            cbyte = FC_READ_HOLD;
        else if (q.idx == 9'h002)
            cbyte = q2;
        else if (q.idx < 9'h003 + 9'(q2))
            cbyte = didx[0] ? cword[7:0] : cword[15:8];
        else if (q.idx == 9'h003 + 9'(q2))
            cbyte = q.crc[7:0];
        else
            cbyte = q.crc[15:8];
    end

    // transaction sequencer and lamp logic
    always_comb
    begin
        d = q;
        buf_we = 1'b0;
        buf_waddr = q.len[7:0];
        buf_wdata = h_data;
        d.htx_start = 1'b0;
        d.rtx_start = 1'b0;
        d.link_s = {q.link_s[0], eth_link};
        d.act_s = {q.act_s[0], eth_activity};
        d.amber = q.link_s[1]; // RULE_03
        // heartbeat keeps toggling whenever the clock runs out of reset
        if (q.hb_cnt == 27'(HB_CYCLES - 1))
        begin
            d.hb_cnt = '0;
            d.hb_led = !q.hb_led; // RULE_01
        end
        else
            d.hb_cnt = q.hb_cnt + 27'h0000001;
        // green toggles per period while traffic was seen; the set wins the clear
        if (q.blk_cnt == 27'(BLINK_CYCLES - 1))
        begin
            d.blk_cnt = '0;
            d.green = q.act_seen ? !q.green : 1'b0; // RULE_04
            d.act_seen = q.act_s[1];
        end
        else
        begin
            d.blk_cnt = q.blk_cnt + 27'h0000001;
            d.act_seen = q.act_seen | q.act_s[1];
        end
        case (q.st)
            ST_IDLE:
            begin
                d.len = '0;
                d.idx = '0;
                if (h_valid)
                begin
                    buf_we = 1'b1;
                    d.len = 9'h001;
                    d.serial_led = 1'b1; // RULE_02
                    d.st = ST_HRX;
                end
            end
            ST_HRX:
            begin
                if (h_valid && q.len < 9'(BUF_DEPTH))
                begin
                    buf_we = 1'b1;
                    d.len = q.len + 9'h001;
                end
                if (h_end)
                begin
                    d.crc = CRC_INIT;
                    d.sel = 3'((buf_mem[0] - 8'h01) >> RADIO_GROUP_SHIFT);
                    if (q.len < 9'(MIN_FRAME) || too_long) // RULE_07
                    begin
                        d.serial_led = 1'b0;
                        d.st = ST_IDLE;
                    end
                    else if (cache_hit)
                        d.st = ST_CTX; // RULE_12
                    else
                    begin
                        d.radio_led[d.sel] = 1'b1; // RULE_05
                        d.st = ST_RTX;
                    end
                end
            end
            ST_RTX:
            begin
                if (!r_busy && !q.rtx_start)
                begin
                    if (q.idx == q.len)
                    begin
                        d.len = '0;
                        d.tmo = '0;
                        d.st = ST_RWAIT;
                    end
                    else
                    begin
                        d.rtx_data = buf_mem[q.idx[7:0]];
                        d.rtx_start = 1'b1;
                        d.idx = q.idx + 9'h001;
                    end
                end
            end
            ST_RWAIT:
            begin
                d.tmo = q.tmo + 29'h00000001;
                d.idx = '0;
                if (r_valid && q.len < 9'(BUF_DEPTH))
                begin
                    buf_we = 1'b1;
                    buf_wdata = r_data;
                    d.len = q.len + 9'h001;
                end
                if (r_end && q.len != 9'h000)
                    d.st = ST_HTX;
                else if (q.tmo == 29'(TIMEOUT_CYCLES - 1))
                begin
                    d.radio_led = '0; // RULE_06
                    d.serial_led = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            ST_HTX:
            begin
                if (!h_busy && !q.htx_start)
                begin
                    if (q.idx == q.len)
                    begin
                        d.radio_led = '0; // RULE_05
                        d.serial_led = 1'b0; // RULE_02
                        d.st = ST_IDLE;
                    end
                    else
                    begin
                        d.htx_data = buf_mem[q.idx[7:0]];
                        d.htx_start = 1'b1;
                        d.idx = q.idx + 9'h001;
                    end
                end
            end
            ST_CTX:
            begin
                // reply built on the fly from cache, crc follows the data
                if (!h_busy && !q.htx_start)
                begin
                    if (q.idx == 9'h005 + 9'(q2))
                    begin
                        d.serial_led = 1'b0; // RULE_02
                        d.st = ST_IDLE;
                    end
                    else
                    begin
                        d.htx_data = cbyte;
                        d.htx_start = 1'b1;
                        d.idx = q.idx + 9'h001;
                        if (q.idx < 9'h003 + 9'(q2))
                            d.crc = crc_step(q.crc, cbyte);
                    end
                end
            end
            default:
                d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            q <= '{st: ST_IDLE, default: '0};
        else
            q <= d;
    end

    // frame and cache storage; no reset needed on data
    always_ff @(posedge mclk)
    begin
        if (buf_we)
            buf_mem[buf_waddr] <= buf_wdata;
        if (cache_we && cache_addr < 7'(MAX_REGS))
            cache_mem[cache_addr] <= cache_wdata;
    end

    assign led_heartbeat = q.hb_led;
    assign led_serial = q.serial_led;
    assign led_eth_amber = q.amber;
    assign led_eth_green = q.green;
    assign led_radio = q.radio_led;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_serial_on: assert property (q.st == ST_IDLE && h_valid |=> led_serial) // RULE_02
        else $error("serial lamp not lit on request");
    a_serial_off: assert property (q.st == ST_HTX ##1 q.st == ST_IDLE |-> !led_serial) // RULE_02
        else $error("serial lamp left on after response");
    a_radio_lamp: assert property (q.st == ST_RTX |-> led_radio[q.sel]) // RULE_05
        else $error("radio lamp off during request");
    a_radio_timeout: assert property (q.st == ST_RWAIT && !r_end
        && q.tmo == 29'(TIMEOUT_CYCLES - 1) |=> q.st == ST_IDLE && led_radio == 8'h00) // RULE_06
        else $error("radio attempt not abandoned");
    a_read_limit: assert property ($rose(q.st == ST_RTX) |-> !too_long) // RULE_07
        else $error("oversized read forwarded");
    a_cache_quiet: assert property (q.st == ST_CTX |-> !q.rtx_start && !r_busy) // RULE_12
        else $error("radio used for cached read");
    a_heartbeat: assert property (q.hb_cnt == 27'(HB_CYCLES - 1) |=> $changed(led_heartbeat)) // RULE_01
        else $error("heartbeat stalled");
    a_amber_link: assert property (##3 led_eth_amber == $past(eth_link, 3)) // RULE_03
        else $error("amber lamp not following link");
    a_green_idle: assert property (!q.act_seen && q.blk_cnt == 27'(BLINK_CYCLES - 1)
        |=> !led_eth_green) // RULE_04
        else $error("green lamp lit without traffic");

    c_cached_reply: cover property (q.st == ST_CTX ##1 q.st == ST_IDLE);
    c_radio_reply: cover property (q.st == ST_RWAIT ##1 q.st == ST_HTX);
    c_radio_timeout: cover property (q.st == ST_RWAIT ##1 q.st == ST_IDLE);
endmodule

// >>> verification/mrh_serial_peer.sv
// serial peer model: sends and receives 8-N-1 characters at one divisor
// assumes the caller sits on mclk edges; line idles high between characters
`timescale 1ns/10ps
module mrh_serial_peer #(
    parameter int DIV = 1085
)
(
    input wire logic mclk,
    input wire logic rx_line,
    output logic tx_line
);
    // idle level until the first character
    initial tx_line = 1'b1;

    // start low, data lsb first, stop high, one bit per DIV cycles
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            tx_line <= fr[i];
            repeat (DIV) @(posedge mclk);
        end
    endtask

    // bounded wait for a start bit, then sample each bit in its middle
    task automatic recv_byte(input int limit, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (rx_line !== 1'b0 && n < limit)
        begin
            @(posedge mclk);
            n++;
        end
        if (rx_line === 1'b0)
        begin
            repeat (DIV / 2) @(posedge mclk);
            ok = (rx_line === 1'b0);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(posedge mclk);
                b[i] = rx_line;
            end
            repeat (DIV) @(posedge mclk);
            ok = ok && (rx_line === 1'b1);
        end
    endtask
endmodule

// >>> verification/tb_top.sv
// testbench for the hub serial core: lamps, host port, radio link, cache
// assumes one host peer and one radio peer; long counts shortened by params
`timescale 1ns/10ps
module tb_top;
    import mrh_pkg::*;
    localparam int TO = 100000; // outlasts a one-byte radio reply plus its gap
    localparam int HBC = 16;
    localparam int HGAP = 4000;
    logic mclk, srst, host_rx, host_tx, radio_rx, radio_tx;
    logic eth_link, eth_activity, pf_en, cache_we, led_heartbeat, led_serial;
    logic led_eth_amber, led_eth_green, radio_busy;
    logic [15:0] pf_base, cache_wdata, crc;
    logic [6:0] pf_count, cache_addr;
    logic [7:0] led_radio, rb;
    logic [7:0] fr [$];
    logic [7:0] ex [$];
    logic ok;
    int mismatches = 0;
    int n_tests = 0;

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    mrh_hub #(.TIMEOUT_CYCLES(TO), .HB_CYCLES(HBC), .BLINK_CYCLES(16), .HOST_GAP(HGAP),
        .RADIO_GAP(30000)) u_dut (.mclk(mclk), .srst(srst), .host_rx(host_rx),
        .host_tx(host_tx), .radio_rx(radio_rx), .radio_tx(radio_tx), .eth_link(eth_link),
        .eth_activity(eth_activity), .pf_en(pf_en), .pf_base(pf_base), .pf_count(pf_count),
        .cache_we(cache_we), .cache_addr(cache_addr), .cache_wdata(cache_wdata),
        .led_heartbeat(led_heartbeat), .led_serial(led_serial), .led_eth_amber(led_eth_amber),
        .led_eth_green(led_eth_green), .led_radio(led_radio));
    mrh_serial_peer #(.DIV(HOST_DIV)) u_host (.mclk(mclk), .rx_line(host_tx), .tx_line(host_rx));
    mrh_serial_peer #(.DIV(RADIO_DIV)) u_radio (.mclk(mclk), .rx_line(radio_tx),
        .tx_line(radio_rx));

    // sticky flag: any radio line or lamp activity since last clear
    always @(posedge mclk)
        if (radio_tx !== 1'b1 || led_radio !== 8'h00)
            radio_busy <= 1'b1;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a character that never came ends the run, later checks would hang
    task automatic arrived(input string what);
        chk(what, 16'h0001, {15'h0000, ok});
        if (ok !== 1'b1)
            tally_and_finish();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic send_frame();
        @(posedge mclk);
        foreach (fr[i])
            u_host.send_byte(fr[i]);
    endtask

    // independent crc model, one byte per call
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    task automatic t_reset();
        chk("lamps after reset", 16'h0000, {8'h00, led_radio});
        chk("serial lamp after reset", 16'h0000, {15'h0, led_serial});
        chk("host_tx idle", 16'h0001, {15'h0, host_tx});
        chk("radio_tx idle", 16'h0001, {15'h0, radio_tx});
        $display("test reset done");
    endtask

    task automatic t_heartbeat();
        int n;
        logic v;
        for (int k = 0; k < 2; k++)
        begin
            v = led_heartbeat;
            n = 0;
            while (led_heartbeat === v && n < 40)
            begin
                cyc(1);
                n++;
            end
        end
        chk("heartbeat half period", 16'(HBC), 16'(n));
        $display("test heartbeat done");
    endtask

    task automatic t_eth();
        int n;
        @(posedge mclk);
        eth_link <= 1'b1;
        eth_activity <= 1'b1;
        cyc(3);
        chk("amber early", 16'h0000, {15'h0, led_eth_amber});
        cyc(1);
        chk("amber on", 16'h0001, {15'h0, led_eth_amber});
        @(posedge mclk);
        eth_activity <= 1'b0;
        n = 0;
        while (led_eth_green !== 1'b1 && n < 48)
        begin
            cyc(1);
            n++;
        end
        chk("green blink on", 16'h0001, {15'h0, led_eth_green});
        cyc(48);
        chk("green idle off", 16'h0000, {15'h0, led_eth_green});
        chk("amber steady", 16'h0001, {15'h0, led_eth_amber});
        @(posedge mclk);
        eth_link <= 1'b0;
        cyc(5);
        chk("amber off", 16'h0000, {15'h0, led_eth_amber});
        $display("test ethernet lamps done");
    endtask

    // too short a frame lights the lamp, then is dropped unanswered
    task automatic t_short();
        fr = {8'h11, 8'h03, 8'h00};
        send_frame();
        chk("serial lamp on request", 16'h0001, {15'h0, led_serial});
        cyc(HGAP + 20);
        chk("serial lamp after drop", 16'h0000, {15'h0, led_serial});
        u_host.recv_byte(3000, rb, ok);
        chk("no reply to short", 16'h0000, {15'h0, ok});
        $display("test short frame done");
    endtask

    // one register past the limit: no reply and no radio traffic
    task automatic t_qty();
        @(posedge mclk);
        pf_en <= 1'b1;
        fr = {8'h11, 8'h03, 8'h01, 8'h00, 8'h00, 8'h5D};
        send_frame();
        u_radio.recv_byte(20000, rb, ok);
        chk("radio silent on 93", 16'h0000, {15'h0, ok});
        chk("lamps after 93", 16'h0000, {7'h0, led_serial, led_radio});
        u_host.recv_byte(3000, rb, ok);
        chk("no reply to 93", 16'h0000, {15'h0, ok});
        $display("test quantity limit done");
    endtask

    // forwarded at the radio rate, then abandoned when no reply comes
    task automatic t_timeout();
        int n;
        @(posedge mclk);
        pf_en <= 1'b0;
        fr = {8'h21, 8'h04, 8'h00, 8'h01};
        send_frame();
        foreach (fr[i])
        begin
            u_radio.recv_byte(HGAP + 2 * RADIO_DIV, rb, ok);
            arrived("radio byte");
            chk("radio byte", {8'h00, fr[i]}, {8'h00, rb});
            if (i == 0)
                chk("radio lamp 3", 16'h0104, {7'h0, led_serial, led_radio});
        end
        n = 0;
        while (led_radio !== 8'h00 && n < TO + 2 * RADIO_DIV)
        begin
            cyc(1);
            n++;
        end
        // wait starts half a radio bit after the last byte is read
        chk("timeout window", 16'h0001, {15'h0, n >= TO + RADIO_DIV / 2 - 4
            && n <= TO + RADIO_DIV / 2 + 4});
        chk("serial lamp cleared", 16'h0000, {15'h0, led_serial});
        u_host.recv_byte(2000, rb, ok);
        chk("no reply on timeout", 16'h0000, {15'h0, ok});
        $display("test radio timeout done");
    endtask

    // last cached word, answered from memory at the host rate
    task automatic t_cache();
        @(posedge mclk);
        pf_en <= 1'b1;
        cache_we <= 1'b1;
        cache_addr <= 7'd91;
        cache_wdata <= 16'hA55A;
        @(posedge mclk);
        cache_we <= 1'b0;
        cyc(1);
        radio_busy = 1'b0;
        fr = {8'h11, 8'h03, 8'h01, 8'h5B, 8'h00, 8'h01};
        ex = {8'h11, 8'h03, 8'h02, 8'hA5, 8'h5A};
        crc = CRC_INIT;
        foreach (ex[i])
            crc = crc_step(crc, ex[i]);
        ex.push_back(crc[7:0]);
        ex.push_back(crc[15:8]);
        send_frame();
        foreach (ex[i])
        begin
            u_host.recv_byte(HGAP + 2 * HOST_DIV, rb, ok);
            arrived("host byte");
            chk("host byte", {8'h00, ex[i]}, {8'h00, rb});
            chk("serial lamp in reply", 16'h0001, {15'h0, led_serial});
        end
        cyc(HOST_DIV / 2 + 4);
        chk("serial lamp after reply", 16'h0000, {15'h0, led_serial});
        chk("no radio on hit", 16'h0000, {15'h0, radio_busy});
        $display("test cache hit done");
    endtask

    // radio reply relayed to the host, lamps cleared once it is out
    task automatic t_relay();
        fr = {8'h31, 8'h06, 8'h00, 8'h07};
        send_frame();
        foreach (fr[i])
        begin
            u_radio.recv_byte(HGAP + 2 * RADIO_DIV, rb, ok);
            arrived("relay out");
            chk("relay out", {8'h00, fr[i]}, {8'h00, rb});
        end
        u_radio.send_byte(8'h5A);
        chk("lamps in wait", 16'h0108, {7'h0, led_serial, led_radio});
        u_host.recv_byte(30000 + 2 * HOST_DIV, rb, ok);
        arrived("relay back");
        chk("relay back", 16'h005A, {8'h00, rb});
        cyc(HOST_DIV / 2 + 4);
        chk("lamps after relay", 16'h0000, {7'h0, led_serial, led_radio});
        $display("test radio relay done");
    endtask

    initial
    begin
        srst = 1'b1;
        eth_link = 1'b0;
        eth_activity = 1'b0;
        pf_en = 1'b0;
        pf_base = 16'h0100;
        pf_count = 7'd92;
        cache_we = 1'b0;
        cache_addr = 7'h00;
        cache_wdata = 16'h0000;
        radio_busy = 1'b0;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        cyc(1);
        t_reset();
        t_heartbeat();
        t_eth();
        // each command waits for its answer or drop before the next
        t_short();
        t_qty();
        t_timeout();
        t_cache();
        t_relay();
        tally_and_finish();
    end

    // hang guard
    initial
    begin
        repeat (1500000) @(posedge mclk);
        mismatches++;
        tally_and_finish();
    end
endmodule
